// ---- logic/pgpc_top.sv ----
// Packet GPIO port control: command decode, sampling, PWM and pin setup
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module pgpc_top
	import pgpc_pkg::*;
#(
	parameter int SamplePeriodCycles = SAMPLE_PERIOD_CYC,
	parameter int PwmPeriodCycles = PWM_PERIOD_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	input wire logic bootLoad,
	input wire logic [NUM_PINS-1:0] pinIn,
	input wire logic [NUM_PINS-1:0] altLevel,
	output logic [NUM_PINS-1:0] pinOut,
	output logic [NUM_PINS-1:0] pinOe,
	output logic [NUM_PINS-1:0] pinPullUp,
	output logic [NUM_PINS-1:0] pinPullDn,
	output logic [NUM_PINS-1:0] pinSlow,
	output logic [NUM_PINS-1:0] userMode
);
	localparam int PwmStepCycles = (PwmPeriodCycles / 100 < 1) ? 1 : PwmPeriodCycles / 100;
	localparam int SW = $clog2(SamplePeriodCycles + 1);
	localparam int PW = $clog2(PwmStepCycles + 1);

	pgpc_state_t state_reg;
	pgpc_state_t state_next;
	logic [7:0] cmdType_reg;
	logic [7:0] cmdLen_reg;
	logic [7:0] cmdD0_reg;
	logic [7:0] cmdD1_reg;
	logic [7:0] cmdD2_reg;
	logic [7:0] rspType_reg;
	logic [7:0] rspLen_reg;
	logic [7:0] rspD0_reg;
	logic [7:0] rspD1_reg;
	logic [7:0] rspD2_reg;
	logic [7:0] rspD3_reg;
	logic rspValid_reg;
	logic [7:0] level_reg [NUM_PINS];
	logic [3:0] cfg_reg [NUM_PINS];
	logic [7:0] bootLevel_reg [NUM_PINS];
	logic [3:0] bootCfg_reg [NUM_PINS];
	logic [NUM_PINS-1:0] sampled_reg;
	logic [NUM_PINS-1:0] rise_reg;
	logic [NUM_PINS-1:0] fall_reg;
	logic [SW-1:0] sampleCnt_reg;
	logic [PW-1:0] pwmCnt_reg;
	logic [6:0] pwmStep_reg;
	logic sampleTick;
	logic goStb;
	logic execNow;
	logic idxOk;
	logic cfgOk;
	logic readOk;
	logic saveOk;
	logic [2:0] pinIdx;
	logic [NUM_PINS-1:0] readClr;
	logic [NUM_PINS-1:0] newRise;
	logic [NUM_PINS-1:0] newFall;
	logic [NUM_PINS-1:0] userWant;

	assign goStb = regWrStb && regAddr == OFF_CMD_GO;
	assign execNow = state_reg == PGPC_EXEC;
	assign pinIdx = cmdD0_reg[2:0];
	assign idxOk = cmdD0_reg < 8'(NUM_PINS);
	assign cfgOk = cmdType_reg == CMD_CFG && (cmdLen_reg == 8'h02 || cmdLen_reg == 8'h03)
		&& idxOk && cmdD1_reg <= LEVEL_HIGH;
	assign readOk = cmdType_reg == CMD_READ && cmdLen_reg == 8'h01 && idxOk;
	assign saveOk = cmdType_reg == CMD_SAVE && cmdLen_reg == 8'h00;

	// Command sequencer
	always_comb begin
		case (state_reg)
			PGPC_IDLE: state_next = goStb ? PGPC_EXEC : PGPC_IDLE;
			PGPC_EXEC: state_next = PGPC_IDLE;
			default: state_next = PGPC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= PGPC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Command byte registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmdType_reg <= 8'h00;
			cmdLen_reg <= 8'h00;
			cmdD0_reg <= 8'h00;
			cmdD1_reg <= 8'h00;
			cmdD2_reg <= 8'h00;
		end else if (regWrStb) begin
			case (regAddr)
				OFF_CMD_TYPE: cmdType_reg <= regWrData;
				OFF_CMD_LEN: cmdLen_reg <= regWrData;
				OFF_CMD_D0: cmdD0_reg <= regWrData;
				OFF_CMD_D1: cmdD1_reg <= regWrData;
				OFF_CMD_D2: cmdD2_reg <= regWrData;
				default: cmdType_reg <= cmdType_reg;
			endcase
		end
	end

	// Reply packet
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rspType_reg <= 8'h00;
			rspLen_reg <= 8'h00;
			rspD0_reg <= 8'h00;
			rspD1_reg <= 8'h00;
			rspD2_reg <= 8'h00;
			rspD3_reg <= 8'h00;
			rspValid_reg <= 1'b0;
		end else if (execNow) begin
			rspValid_reg <= 1'b1;
			rspD0_reg <= 8'h00;
			rspD1_reg <= 8'h00;
			rspD2_reg <= 8'h00;
			rspD3_reg <= 8'h00;
			rspLen_reg <= 8'h00;
			if (readOk) begin
				rspType_reg <= RSP_READ;
				rspLen_reg <= LEN_READ_RSP;
				rspD0_reg <= cmdD0_reg;
				rspD1_reg <= pgpc_state_byte(rise_reg[pinIdx], fall_reg[pinIdx],
					sampled_reg[pinIdx]);
				rspD2_reg <= level_reg[pinIdx];
				rspD3_reg <= {4'h0, cfg_reg[pinIdx]};
			end else if (cfgOk || saveOk) begin
				rspType_reg <= ACK_FLAG | cmdType_reg;
			end else begin
				rspType_reg <= ERR_FLAG | cmdType_reg;
			end
		end else if (goStb) begin
			rspValid_reg <= 1'b0;
		end
	end

	// Pin setup and boot copy
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				level_reg[i] <= DFLT_LEVELS[i*8 +: 8];
				cfg_reg[i] <= DFLT_CFGS[i*4 +: 4];
				bootLevel_reg[i] <= DFLT_LEVELS[i*8 +: 8];
				bootCfg_reg[i] <= DFLT_CFGS[i*4 +: 4];
			end
		end else if (bootLoad) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				level_reg[i] <= bootLevel_reg[i];
				cfg_reg[i] <= bootCfg_reg[i];
			end
		end else if (execNow && cfgOk) begin
			level_reg[pinIdx] <= cmdD1_reg;
			if (cmdLen_reg == 8'h03) begin
				cfg_reg[pinIdx] <= cmdD2_reg[3:0];
			end
		end else if (execNow && saveOk) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				bootLevel_reg[i] <= level_reg[i];
				bootCfg_reg[i] <= cfg_reg[i];
			end
		end
	end

	// Free running sample timer
	// independent of reads
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sampleCnt_reg <= '0;
		end else if (sampleTick) begin
			sampleCnt_reg <= '0;
		end else begin
			sampleCnt_reg <= sampleCnt_reg + 1'b1;
		end
	end
	assign sampleTick = sampleCnt_reg == SW'(SamplePeriodCycles - 1);

	assign newRise = sampleTick ? (pinIn & ~sampled_reg) : '0;
	assign newFall = sampleTick ? (~pinIn & sampled_reg) : '0;
	assign readClr = (execNow && readOk) ? NUM_PINS'(1) << pinIdx : '0;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sampled_reg <= '0;
		end else if (sampleTick) begin
			sampled_reg <= pinIn;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rise_reg <= '0;
			fall_reg <= '0;
		end else begin
			rise_reg <= (rise_reg & ~readClr) | newRise;
			fall_reg <= (fall_reg & ~readClr) | newFall;
		end
	end

	// PWM timebase: 100 steps per period
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pwmCnt_reg <= '0;
			pwmStep_reg <= 7'h00;
		end else if (pwmCnt_reg == PW'(PwmStepCycles - 1)) begin
			pwmCnt_reg <= '0;
			pwmStep_reg <= (pwmStep_reg == PWM_STEPS - 7'h01) ? 7'h00 : pwmStep_reg + 7'h01;
		end else begin
			pwmCnt_reg <= pwmCnt_reg + 1'b1;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			userWant[i] = {1'b0, pwmStep_reg} < level_reg[i];
		end
	end

	for (genvar g = 0; g < NUM_PINS; g++) begin : gPin
		pgpc_pin_drive uDrive (
			.clk_sys(clk_sys),
			.rst_b(rst_b),
			.pinCfg(cfg_reg[g]),
			.userWant(userWant[g]),
			.altWant(altLevel[g]),
			.padOut(pinOut[g]),
			.padOe(pinOe[g]),
			.padPullUp(pinPullUp[g]),
			.padPullDn(pinPullDn[g]),
			.padSlow(pinSlow[g])
		);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			userMode <= '0;
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				userMode[i] <= cfg_reg[i][CFG_FUNC_BIT];
			end
		end
	end

	// Read port: data stand one cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
		end else if (regRdStb) begin
			case (regAddr)
				OFF_CMD_TYPE: regRdData <= cmdType_reg;
				OFF_CMD_LEN: regRdData <= cmdLen_reg;
				OFF_CMD_D0: regRdData <= cmdD0_reg;
				OFF_CMD_D1: regRdData <= cmdD1_reg;
				OFF_CMD_D2: regRdData <= cmdD2_reg;
				OFF_RSP_TYPE: regRdData <= rspType_reg;
				OFF_RSP_LEN: regRdData <= rspLen_reg;
				OFF_RSP_D0: regRdData <= rspD0_reg;
				OFF_RSP_D1: regRdData <= rspD1_reg;
				OFF_RSP_D2: regRdData <= rspD2_reg;
				OFF_RSP_D3: regRdData <= rspD3_reg;
				OFF_STATUS: regRdData <= {6'h00, execNow, rspValid_reg};
				default: regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence execCfg;
		execNow && cfgOk && !bootLoad;
	endsequence
	sequence execRead;
		execNow && readOk;
	endsequence

	cfg_ack_a: assert property (execCfg |=> rspType_reg == RSP_CFG && rspLen_reg == 8'h00)
		else $error("configure ack wrong");
	read_reply_a: assert property (execRead |=> rspType_reg == RSP_READ
		&& rspLen_reg == LEN_READ_RSP && rspD0_reg == $past(cmdD0_reg))
		else $error("read reply wrong");
	sample_take_a: assert property (sampleTick |=> sampled_reg == $past(pinIn))
		else $error("sample not taken");
	sample_hold_a: assert property (!sampleTick |=> $stable(sampled_reg))
		else $error("level moved between samples");
	edge_keep_a: assert property (sampleTick && pinIn[3] && !sampled_reg[3] && !goStb
		|=> rise_reg[3] [*2])
		else $error("rising edge lost");
	flag_clear_a: assert property ((execRead and (pinIdx == 3'h3 && !sampleTick))
		|=> !rise_reg[3] && !fall_reg[3])
		else $error("edge flags not cleared");
	bad_keep_a: assert property (execNow && cmdType_reg == CMD_CFG && !cfgOk
		&& !bootLoad |=> $stable(level_reg[0]) && $stable(cfg_reg[0])
		&& $stable(level_reg[4]) && $stable(cfg_reg[4]))
		else $error("invalid command changed setup");
	mode_keep_a: assert property ((execCfg and (cmdLen_reg == 8'h02))
		|=> $stable(cfg_reg[pinIdx]) && level_reg[$past(pinIdx)] == $past(cmdD1_reg))
		else $error("short configure touched mode");
	cfg_zero_a: assert property (execRead |=> rspD3_reg[7:4] == 4'h0
		&& rspD2_reg <= LEVEL_HIGH)
		else $error("config readback bad");
endmodule

// ---- logic/pgpc_pkg.sv ----
// Constants and types for the packet GPIO port control block
// Functional notes
// - Configure command 0x22 is answered by type 0x62 with no data bytes.
// - Every pin is sampled as input continuously at 32 Hz.
// - Rising and falling transitions are remembered between host queries.
// - Reported levels come from the slow sampling and are thus debounced.
// - Output byte: 0 low, 1..99 PWM duty at 100 Hz, 100 high, above invalid.
// - Config byte: bit 3 function select, bits 2..0 drive mode, upper bits zero.
// - Modes 000 up/pull-down, 001 push-pull, 010 high-Z, 011 pull-up/down.
// - Modes 100 slow up/high-Z, 101 slow push-pull, 111 high-Z/slow down.
// - Function bit 0 gives default function, 1 gives user control of pin.
// - Save command 0x04 stores pin setup; it returns on power-up. The code restores it only on a bootLoad pulse; reset loads the defaults.
// - Read command 0x23 carries one pin index 0..4; higher indexes reserved.
// - Read reply is type 0x63 with 4 bytes, first echoes the pin index.
// - Second reply byte: level, falling and rising flags; flags clear once read.
// - Reported level is the real sampled pin, not the commanded value.
// - Sampling runs free of reads; pulses between samples go unseen.
// - Third reply byte is the stored level or duty, 0..100.
// - Fourth reply byte is the config byte with upper four bits zero.
package pgpc_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int SAMPLE_HZ = 32;
	localparam int PWM_HZ = 100;
	localparam int SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_HZ;
	localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
	localparam int NUM_PINS = 5;

	localparam logic [7:0] CMD_SAVE = 8'h04;
	localparam logic [7:0] CMD_CFG = 8'h22;
	localparam logic [7:0] CMD_READ = 8'h23;
	localparam logic [7:0] ACK_FLAG = 8'h40;
	localparam logic [7:0] ERR_FLAG = 8'hC0;
	localparam logic [7:0] RSP_CFG = 8'h62;
	localparam logic [7:0] RSP_READ = 8'h63;
	localparam logic [7:0] LEN_READ_RSP = 8'h04;
	localparam logic [7:0] LEVEL_HIGH = 8'h64;
	localparam logic [6:0] PWM_STEPS = 7'h64;

	localparam int CFG_FUNC_BIT = 3;
	localparam logic [2:0] MODE_UP_PULLDN = 3'h0;
	localparam logic [2:0] MODE_PUSHPULL = 3'h1;
	localparam logic [2:0] MODE_HIZ = 3'h2;
	localparam logic [2:0] MODE_PULLUP_DN = 3'h3;
	localparam logic [2:0] MODE_SLOW_UP = 3'h4;
	localparam logic [2:0] MODE_SLOW_PP = 3'h5;
	localparam logic [2:0] MODE_RSVD = 3'h6;
	localparam logic [2:0] MODE_SLOW_DN = 3'h7;

	localparam logic [39:0] DFLT_LEVELS = 40'h64_0000_6400;
	localparam logic [19:0] DFLT_CFGS = 20'h72230;

	localparam logic [3:0] OFF_CMD_TYPE = 4'h0;
	localparam logic [3:0] OFF_CMD_LEN = 4'h1;
	localparam logic [3:0] OFF_CMD_D0 = 4'h2;
	localparam logic [3:0] OFF_CMD_D1 = 4'h3;
	localparam logic [3:0] OFF_CMD_D2 = 4'h4;
	localparam logic [3:0] OFF_CMD_GO = 4'h5;
	localparam logic [3:0] OFF_RSP_TYPE = 4'h8;
	localparam logic [3:0] OFF_RSP_LEN = 4'h9;
	localparam logic [3:0] OFF_RSP_D0 = 4'hA;
	localparam logic [3:0] OFF_RSP_D1 = 4'hB;
	localparam logic [3:0] OFF_RSP_D2 = 4'hC;
	localparam logic [3:0] OFF_RSP_D3 = 4'hD;
	localparam logic [3:0] OFF_STATUS = 4'hE;

	typedef enum logic [1:0] {
		PGPC_IDLE = 2'b01,
		PGPC_EXEC = 2'b10
	} pgpc_state_t;

	// State and edge byte of the read reply
	function automatic logic [7:0] pgpc_state_byte(input logic rise, input logic fall,
			input logic lvl);
		pgpc_state_byte = {5'h00, rise, fall, lvl};
	endfunction
endpackage

// ---- logic/pgpc_pin_drive.sv ----
// One pin driver: drive mode and function select to pad controls
`timescale 1ns/10ps
module pgpc_pin_drive
	import pgpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [3:0] pinCfg,
	input wire logic userWant,
	input wire logic altWant,
	output logic padOut,
	output logic padOe,
	output logic padPullUp,
	output logic padPullDn,
	output logic padSlow
);
	logic want;

	// Function select picks user or default level
	// function select
	assign want = pinCfg[CFG_FUNC_BIT] ? userWant : altWant;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			padOut <= 1'b0;
			padOe <= 1'b0;
			padPullUp <= 1'b0;
			padPullDn <= 1'b0;
			padSlow <= 1'b0;
		end else begin
			padOut <= want;
			padPullUp <= 1'b0;
			padPullDn <= 1'b0;
			padSlow <= pinCfg[2];
			case (pinCfg[2:0])
				MODE_UP_PULLDN: begin
					padOe <= want;
					padPullDn <= ~want;
				end
				MODE_PUSHPULL: padOe <= 1'b1;
				MODE_PULLUP_DN: begin
					padOe <= ~want;
					padPullUp <= want;
				end
				MODE_SLOW_UP: padOe <= want;
				MODE_SLOW_PP: padOe <= 1'b1;
				MODE_SLOW_DN: padOe <= ~want;
				default: padOe <= 1'b0;
			endcase
		end
	end

	hiz_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		pinCfg[2:0] == MODE_HIZ |=> !padOe && !padPullUp && !padPullDn)
		else $error("high-Z mode drives the pin");
	slow_up_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		pinCfg[2:0] == MODE_SLOW_UP && !want |=> !padOe && padSlow)
		else $error("slow up mode drives a low");
endmodule

// ---- bench/pgpc_host_model.sv ----
// Host model: register-port master that sends command packets
`timescale 1ns/10ps
module pgpc_host_model
	import pgpc_pkg::*;
(
	input wire logic clk_sys,
	output logic [3:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrStb,
	output logic regRdStb
);
	int gapCycles = 0;
	initial begin
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		repeat (gapCycles + 1) @(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk_sys);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk_sys);
		regRdStb <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] t, input logic [7:0] n, input logic [7:0] d0,
			input logic [7:0] d1, input logic [7:0] d2);
		wr(OFF_CMD_TYPE, t);
		wr(OFF_CMD_LEN, n);
		wr(OFF_CMD_D0, d0);
		wr(OFF_CMD_D1, d1);
		wr(OFF_CMD_D2, d2 & 8'h0F);
		wr(OFF_CMD_GO, 8'h01);
		@(posedge clk_sys);
	endtask
endmodule

// ---- bench/tb_packet_gpio_port_control.sv ----
// Self-checking bench for the packet GPIO port control block
`timescale 1ns/10ps
module tb_packet_gpio_port_control
	import pgpc_pkg::*;
();
	localparam int SMP_T = 16;
	localparam int PWM_T = 400;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] regAddr;
	logic [7:0] regWrData;
	logic regWrStb;
	logic regRdStb;
	logic [7:0] regRdData;
	logic bootLoad = 1'b0;
	logic [4:0] pinIn = 5'h00;
	logic [4:0] altLevel = 5'h00;
	logic [4:0] pinOut, pinOe, pinPullUp, pinPullDn, pinSlow, userMode;
	int fail_count = 0;
	int checks = 0;
	logic [7:0] expQ[$];
	logic rdSeen = 1'b0;

	always #25 clk_sys = ~clk_sys;

	pgpc_host_model i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb));
	pgpc_top #(.SamplePeriodCycles(SMP_T), .PwmPeriodCycles(PWM_T)) i_dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.bootLoad(bootLoad), .pinIn(pinIn), .altLevel(altLevel), .pinOut(pinOut),
		.pinOe(pinOe), .pinPullUp(pinPullUp), .pinPullDn(pinPullDn), .pinSlow(pinSlow),
		.userMode(userMode));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Mismatches %0d, comparisons %0d", fail_count, checks);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Read watcher: oldest note against the data cycle
	always @(posedge clk_sys) begin
		if (rdSeen) begin
			if (expQ.size() > 0)
				check(regRdData, expQ.pop_front());
			else begin
				fail_count++;
				$display("Error at %0t: seen %h expected none", $time, regRdData);
			end
		end
		rdSeen <= regRdStb;
	end
	task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
		expQ.push_back(e);
		i_host.rd(a);
	endtask
	task automatic reply(input logic [7:0] t);
		rdChk(OFF_RSP_TYPE, t);
		rdChk(OFF_RSP_LEN, 8'h00);
		rdChk(OFF_STATUS, 8'h01);
	endtask
	task automatic query(input logic [7:0] p, input logic [7:0] s, input logic [7:0] l,
			input logic [7:0] c);
		i_host.cmd(CMD_READ, 8'h01, p, 8'h00, 8'h00);
		rdChk(OFF_RSP_TYPE, RSP_READ);
		rdChk(OFF_RSP_LEN, LEN_READ_RSP);
		rdChk(OFF_RSP_D0, p);
		rdChk(OFF_RSP_D1, s);
		rdChk(OFF_RSP_D2, l);
		rdChk(OFF_RSP_D3, c);
	endtask
	task automatic pinChk(input int p, input logic [2:0] m, input logic w);
		logic oe;
		oe = (m == 3'h1 || m == 3'h5) ? 1'b1 : (m == 3'h0 || m == 3'h4) ? w :
			(m == 3'h3 || m == 3'h7) ? ~w : 1'b0;
		check(8'(pinOe[p]), 8'(oe));
		check(8'(pinOut[p]), 8'(w));
		check(8'(pinPullUp[p]), 8'(m == 3'h3 && w));
		check(8'(pinPullDn[p]), 8'(m == 3'h0 && !w));
		check(8'(pinSlow[p]), 8'(m[2]));
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		final_report();
	end

	initial begin
		int lvl;
		int hi;
		logic [7:0] bad;
		void'($urandom(32'heed3a7d2));
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3 * SMP_T) @(posedge clk_sys);
		for (int p = 0; p < NUM_PINS; p++)
			query(8'(p), 8'h00, DFLT_LEVELS[p*8 +: 8], {4'h0, DFLT_CFGS[p*4 +: 4]});
		for (int m = 0; m < 8; m++) begin
			for (int w = 0; w < 2; w++) begin
				i_host.cmd(CMD_CFG, 8'h03, 8'h00, w ? LEVEL_HIGH : 8'h00, 8'(8 + m));
				reply(RSP_CFG);
				repeat (3) @(posedge clk_sys);
				pinChk(0, 3'(m), 1'(w));
				check(8'(userMode[0]), 8'h01);
			end
		end
		query(8'h00, 8'h00, LEVEL_HIGH, 8'h0F);
		altLevel <= 5'($urandom);
		i_host.cmd(CMD_CFG, 8'h03, 8'h00, LEVEL_HIGH, 8'h01);
		repeat (8) @(posedge clk_sys);
		check(8'(pinOut[0]), 8'(altLevel[0]));
		check(8'(userMode[0]), 8'h00);
		i_host.cmd(CMD_CFG, 8'h03, 8'h04, LEVEL_HIGH, 8'h07);
		i_host.cmd(CMD_CFG, 8'h02, 8'h04, 8'h37, 8'h00);
		query(8'h04, 8'h00, 8'h37, 8'h07);
		bad = 8'(101 + $urandom_range(154));
		i_host.cmd(CMD_CFG, 8'h03, 8'h04, bad, 8'h0A);
		reply(ERR_FLAG | CMD_CFG);
		bad = 8'(5 + $urandom_range(250));
		i_host.cmd(CMD_CFG, 8'h03, bad, 8'h00, 8'h0A);
		reply(ERR_FLAG | CMD_CFG);
		i_host.cmd(CMD_READ, 8'h01, bad, 8'h00, 8'h00);
		reply(ERR_FLAG | CMD_READ);
		query(8'h04, 8'h00, 8'h37, 8'h07);
		lvl = $urandom_range(99, 1);
		i_host.cmd(CMD_CFG, 8'h03, 8'h02, 8'(lvl), 8'h09);
		repeat (PWM_T) @(posedge clk_sys);
		hi = 0;
		repeat (PWM_T) @(posedge clk_sys) hi += int'(pinOut[2]);
		check(8'(hi - 4 * lvl), 8'h00);
		pinIn[3] <= 1'b1;
		repeat (3 * SMP_T) @(posedge clk_sys);
		pinIn[3] <= 1'b0;
		repeat (3 * SMP_T) @(posedge clk_sys);
		pinIn[3] <= 1'b1;
		repeat (3 * SMP_T) @(posedge clk_sys);
		query(8'h03, 8'h07, 8'h00, 8'h02);
		query(8'h03, 8'h01, 8'h00, 8'h02);
		pinIn[3] <= 1'b0;
		repeat (SMP_T + 1) @(posedge clk_sys);
		query(8'h03, 8'h02, 8'h00, 8'h02);
		i_host.gapCycles = 3;
		i_host.cmd(CMD_SAVE, 8'h00, 8'h00, 8'h00, 8'h00);
		reply(ACK_FLAG | CMD_SAVE);
		i_host.cmd(CMD_CFG, 8'h03, 8'h02, 8'h00, 8'h0D);
		@(posedge clk_sys);
		bootLoad <= 1'b1;
		@(posedge clk_sys);
		bootLoad <= 1'b0;
		query(8'h02, 8'h00, 8'(lvl), 8'h09);
		repeat (4) @(posedge clk_sys);
		final_report();
	end
endmodule
